// ### rtl/mpeg_status_consts.vh
// local register addresses, field positions and reset values of the status group
// included by the status register bank; definitions only
`ifndef MPEG_STATUS_CONSTS_VH
`define MPEG_STATUS_CONSTS_VH

// =====================================================
// local addresses
`define ADDR_CONTINUE 8'h00
`define ADDR_EVENT_FLAGS 8'h1c
`define ADDR_EVENT_MASK 8'h1d
`define ADDR_DECODED_HDR 8'h21
`define ADDR_USED_HDR 8'h22
`define ADDR_ERROR_REPORT 8'h24

// =====================================================
// event register bit positions
`define EVT_SYNC_LOST 0
`define EVT_SYNC_GAINED 1
`define EVT_CRC_FAIL 2
`define EVT_STOP 3
`define EVT_DATA_READY 4
`define EVT_WIDTH 5

// =====================================================
// reset values
`define EVENT_RESET 5'h00
`define MASK_RESET 5'h00
`define HEADER_RESET 24'h000000
`define ERROR_RESET 8'h00

// =====================================================
// field layouts
`define HDR_BYTES 3
// used header byte 1: bits 7..4 and bit 2 are forced high on each header load
`define USED_BYTE1_FORCE 8'hf4
// undefined bits read as zero
`define HDR_BYTE2_DEFINED 8'hfc
`define ERR_DEFINED 8'hcf

`endif

// ### rtl/mpeg_decoder_status_irq_regs.v
// status and interrupt register group of the audio source decoder
// assumes a byte-wide local register port fed by the control interface,
// and header/error data plus status flags from the decoder core on CLK
//
// Functional notes
// - read-only event register at 1CH, five bits
// - data-ready flag rising sets data-ready event
// - stop input rising edge sets stop event
// - failed frame CRC sets CRC event
// - in-sync set/clear sets gained/lost events
// - event bits one when occurred, reset zero
// - mask one unmasks, reset all masked
// - mask bit gates same-position event only
// - masked events recorded, not on pin
// - decoded header block at 21H, always readable
// - header byte 1 field layout
// - header bytes 2 and 3 field layout
// - used header block at 22H
// - used byte1 bits 7..4, 2 forced one; reads 00H until the first header load
// - emphasis monitored; de-emphasis applied internally
// - error report at 24H, bits 5,4 undefined
// - bit 7 allocation information valid
// - bit 6 frame decoded normally
// - bits 3..0 scale factor CRC results
// - scale factor bits map to sub-band blocks
// - address 00H continues interrupted block read
`timescale 1ns/1ps
`include "mpeg_status_consts.vh"

module mpeg_decoder_status_irq_regs (
	// clock and reset
	input wire CLK,
	input wire SRST,
	// local register port from the control interface
	input wire [7:0] REG_ADDR,
	input wire REG_RD,
	input wire REG_WR,
	input wire [7:0] REG_WDATA,
	output reg [7:0] REG_RDATA,
	output reg REG_RVALID,
	// status flags and events from the decoder core
	input wire DATA_READY_FLAG,
	input wire IN_SYNC_FLAG,
	input wire CRC_FAIL,
	// stop pin, asynchronous
	input wire STOP_PIN,
	// per-frame header and error data from the decoder core
	input wire HEADER_LOAD,
	input wire [23:0] DECODED_HEADER,
	input wire [23:0] USED_HEADER,
	input wire ERROR_LOAD,
	input wire [7:0] ERROR_REPORT,
	// outputs
	output wire INTERRUPT_OUT_PIN,
	output wire [1:0] EMPHASIS_FIELD
);

// =====================================================
// stop pin synchroniser and edge detect
reg stop_s1;
reg stop_s2;
reg stop_s3;
reg stop_level;
always @(posedge CLK) begin
	if (SRST) begin
		stop_s1 <= 1'b0;
		stop_s2 <= 1'b0;
		stop_s3 <= 1'b0;
		stop_level <= 1'b0;
	end else begin
		// the first stage may go metastable; only later stages reach logic
		stop_s1 <= STOP_PIN;
		stop_s2 <= stop_s1;
		stop_s3 <= stop_s2;
		// a change counts only once the last two stages agree
		if (stop_s2 == stop_s3)
			stop_level <= stop_s3;
	end
end

// =====================================================
// flag edge detection
reg ready_prev;
reg sync_prev;
always @(posedge CLK) begin
	if (SRST) begin
		ready_prev <= 1'b0;
		sync_prev <= 1'b0;
	end else begin
		ready_prev <= DATA_READY_FLAG;
		sync_prev <= IN_SYNC_FLAG;
	end
end

wire stop_rise;
wire [`EVT_WIDTH-1:0] event_set;
wire [`EVT_WIDTH-1:0] event_clr;
reg stop_level_prev;
always @(posedge CLK) begin
	if (SRST)
		stop_level_prev <= 1'b0;
	else
		stop_level_prev <= stop_level;
end
assign stop_rise = stop_level & ~stop_level_prev;
wire ready_rise;
wire sync_rise;
wire sync_fall;
assign ready_rise = DATA_READY_FLAG & ~ready_prev;
assign sync_rise = IN_SYNC_FLAG & ~sync_prev;
assign sync_fall = ~IN_SYNC_FLAG & sync_prev;
// flags already high at reset release report once on the first edge
assign event_set[`EVT_DATA_READY] = ready_rise;
assign event_set[`EVT_STOP] = stop_rise;
// crc failure event, one per high cycle
assign event_set[`EVT_CRC_FAIL] = CRC_FAIL;
assign event_set[`EVT_SYNC_GAINED] = sync_rise;
assign event_set[`EVT_SYNC_LOST] = sync_fall;

// =====================================================
// event and mask registers
wire rd_events;
wire wr_mask;
assign rd_events = REG_RD && (REG_ADDR == `ADDR_EVENT_FLAGS);
assign wr_mask = REG_WR && (REG_ADDR == `ADDR_EVENT_MASK);
assign event_clr = rd_events ? {`EVT_WIDTH{1'b1}} : {`EVT_WIDTH{1'b0}};

wire [`EVT_WIDTH-1:0] event_flags;
wire [`EVT_WIDTH-1:0] event_unmask_bits;
wire [`EVT_WIDTH-1:0] irq_bits;
localparam [`EVT_WIDTH-1:0] EVENT_INIT = `EVENT_RESET;
localparam [`EVT_WIDTH-1:0] MASK_INIT = `MASK_RESET;

// one cell per event bit: flag, its mask and its pin share
genvar gi;
generate
	for (gi = 0; gi < `EVT_WIDTH; gi = gi + 1) begin : g_event_bit
		reg flag;
		reg unmask;
		wire next_flag;
		// sticky, set wins over read clear
		// a set landing in the clearing cycle survives to the next read
		assign next_flag = (flag & ~event_clr[gi]) | event_set[gi];
		always @(posedge CLK) begin
			if (SRST) begin
				flag <= EVENT_INIT[gi];
				unmask <= MASK_INIT[gi];
			end else begin
				flag <= next_flag;
				if (wr_mask)
					unmask <= REG_WDATA[gi];
			end
		end
		assign event_flags[gi] = flag;
		assign event_unmask_bits[gi] = unmask;
		assign irq_bits[gi] = flag & unmask;
	end
endgenerate

assign INTERRUPT_OUT_PIN = |irq_bits;

// =====================================================
// header snapshots, one cell per header byte
// cell hi holds word bits 8*hi up; cell 2 is the first byte read
localparam [23:0] HDR_INIT = `HEADER_RESET;
localparam [23:0] USED_FORCE = {`USED_BYTE1_FORCE, 16'h0000};
localparam [23:0] HDR_KEEP = {8'hff, `HDR_BYTE2_DEFINED, 8'hff};
wire [23:0] decoded_frame_header;
wire [23:0] used_frame_header;

genvar hi;
generate
	for (hi = 0; hi < `HDR_BYTES; hi = hi + 1) begin : g_hdr_byte
		reg [7:0] decoded_byte;
		reg [7:0] used_byte;
		always @(posedge CLK) begin
			if (SRST) begin
				decoded_byte <= HDR_INIT[8*hi +: 8];
				used_byte <= HDR_INIT[8*hi +: 8];
			end else if (HEADER_LOAD) begin
				// decoded header latched whatever the sync state
				// byte 1 tail, id, layer, protect
				decoded_byte <= DECODED_HEADER[8*hi +: 8] & HDR_KEEP[8*hi +: 8];
				used_byte <= (USED_HEADER[8*hi +: 8] | USED_FORCE[8*hi +: 8])
					& HDR_KEEP[8*hi +: 8];
			end
		end
		assign decoded_frame_header[8*hi +: 8] = decoded_byte;
		assign used_frame_header[8*hi +: 8] = used_byte;
	end
endgenerate

// =====================================================
// error report snapshot
// content is not gated by sync; the host judges validity
reg [7:0] frame_error_report;
always @(posedge CLK) begin
	if (SRST) begin
		frame_error_report <= `ERROR_RESET;
	end else begin
		// scale factor results in bits 3..0
		// bit n covers sub-band block n
		if (ERROR_LOAD)
			frame_error_report <= ERROR_REPORT & `ERR_DEFINED;
	end
end

// emphasis handed to the audio path for de-emphasis
assign EMPHASIS_FIELD = used_frame_header[1:0];

// =====================================================
// restricted block transfer tracking
// 0: none, 1: decoded header, 2: used header, 3: error report
// a read of 1CH or an unmapped address keeps the saved place
localparam BLK_NONE = 2'd0;
localparam BLK_DECODED = 2'd1;
localparam BLK_USED = 2'd2;
localparam BLK_ERROR = 2'd3;

reg [1:0] block_sel;
reg [1:0] byte_index;
reg [1:0] next_block_sel;
reg [1:0] next_byte_index;
reg [1:0] rd_block;
reg [1:0] rd_index;

always @* begin
	next_block_sel = block_sel;
	next_byte_index = byte_index;
	rd_block = BLK_NONE;
	rd_index = 2'd0;
	if (REG_RD) begin
		case (REG_ADDR)
		`ADDR_DECODED_HDR: begin
			rd_block = BLK_DECODED;
		end
		`ADDR_USED_HDR: begin
			rd_block = BLK_USED;
		end
		`ADDR_ERROR_REPORT: begin
			rd_block = BLK_ERROR;
		end
		`ADDR_CONTINUE: begin
			rd_block = block_sel;
			rd_index = byte_index;
		end
		default: begin
			rd_block = BLK_NONE;
		end
		endcase
		if (rd_block != BLK_NONE) begin
			next_block_sel = rd_block;
			// saturates at 3, one past the last header byte
			if (rd_index != 2'd3)
				next_byte_index = rd_index + 2'd1;
			else
				next_byte_index = rd_index;
		end
	end
end

always @(posedge CLK) begin
	if (SRST) begin
		block_sel <= BLK_NONE;
		byte_index <= 2'd0;
	end else begin
		block_sel <= next_block_sel;
		byte_index <= next_byte_index;
	end
end

// =====================================================
// read data mux
function [7:0] header_byte;
	input [23:0] hdr;
	input [1:0] idx;
	begin
		case (idx)
		2'd0: header_byte = hdr[23:16];
		2'd1: header_byte = hdr[15:8];
		2'd2: header_byte = hdr[7:0];
		default: header_byte = 8'h00;
		endcase
	end
endfunction

reg [7:0] next_rdata;
always @* begin
	next_rdata = 8'h00;
	if (rd_events) begin
		next_rdata = {3'b000, event_flags};
	end else begin
		case (rd_block)
		BLK_DECODED: next_rdata = header_byte(decoded_frame_header, rd_index);
		BLK_USED: next_rdata = header_byte(used_frame_header, rd_index);
		// single byte; continuation past it reads zero
		BLK_ERROR: next_rdata = (rd_index == 2'd0) ? frame_error_report : 8'h00;
		default: next_rdata = 8'h00;
		endcase
	end
end

// answer strobe, one cycle after each read
always @(posedge CLK) begin
	if (SRST)
		REG_RVALID <= 1'b0;
	else
		REG_RVALID <= REG_RD;
end

// data holds the last answer until the next read
always @(posedge CLK) begin
	if (SRST)
		REG_RDATA <= 8'h00;
	else if (REG_RD)
		REG_RDATA <= next_rdata;
end

endmodule // mpeg_decoder_status_irq_regs

// ### sim/status_host.sv
// host model on the local register port of the status bank
// assumes a free-running CLK; strobes change at the falling edge only
`timescale 1ns/1ps
module status_host (
	// clock
	input wire CLK,
	// register port
	output reg [7:0] REG_ADDR,
	output reg REG_RD,
	output reg REG_WR,
	output reg [7:0] REG_WDATA,
	input wire [7:0] REG_RDATA,
	input wire REG_RVALID
);
	initial begin
		REG_ADDR = 8'h00;
		REG_RD = 1'b0;
		REG_WR = 1'b0;
		REG_WDATA = 8'h00;
	end
	// released address shows the inverse, never a stale match
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(negedge CLK);
			REG_ADDR = a;
			REG_RD = 1'b1;
			@(negedge CLK);
			REG_RD = 1'b0;
			REG_ADDR = ~a;
			d = REG_RVALID ? REG_RDATA : 8'hxx;
		end
	endtask
	task wr(input [7:0] a, input [4:0] v);
		begin
			@(negedge CLK);
			REG_ADDR = a;
			REG_WDATA = {3'b000, v};
			REG_WR = 1'b1;
			@(negedge CLK);
			REG_WR = 1'b0;
			REG_WDATA = ~REG_WDATA;
		end
	endtask
endmodule // status_host

// ### sim/status_irq_regs_asserts.sv
// checker for the status and interrupt register bank
// sees only the top ports; one clock, synchronous reset
`timescale 1ns/1ps
module status_irq_chk (
	// clock and reset
	input wire CLK,
	input wire SRST,
	// register port
	input wire [7:0] REG_ADDR,
	input wire REG_RD,
	input wire REG_WR,
	input wire [7:0] REG_WDATA,
	input wire [7:0] REG_RDATA,
	input wire REG_RVALID,
	// core side
	input wire IN_SYNC_FLAG,
	input wire CRC_FAIL,
	input wire HEADER_LOAD,
	input wire [23:0] USED_HEADER,
	input wire INTERRUPT_OUT_PIN,
	input wire [1:0] EMPHASIS_FIELD
);
	reg [4:0] m;
	reg ld;
	always @(posedge CLK) begin
		if (SRST) begin
			m <= 5'h00;
			ld <= 1'b0;
		end else begin
			if (REG_WR && REG_ADDR == 8'h1d)
				m <= REG_WDATA[4:0];
			if (HEADER_LOAD)
				ld <= 1'b1;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	a_read_answer: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered once");
	a_no_stray_valid: assert property (!REG_RD |=> !REG_RVALID)
		else $error("answer without read");
	a_crc_raises_irq: assert property (CRC_FAIL && m[2] && !REG_WR |=> INTERRUPT_OUT_PIN)
		else $error("crc event missed pin");
	a_sync_raises_irq: assert property ($rose(IN_SYNC_FLAG) && m[1] && !REG_WR
		|=> INTERRUPT_OUT_PIN)
		else $error("sync event missed pin");
	a_masked_pin_low: assert property (m == 5'h00 |-> !INTERRUPT_OUT_PIN)
		else $error("masked event on pin");
	a_event_top_zero: assert property (REG_RD && REG_ADDR == 8'h1c
		|=> REG_RDATA[7:5] == 3'b000)
		else $error("event upper bits set");
	a_used_forced_ones: assert property (REG_RD && REG_ADDR == 8'h22 && ld
		|=> (REG_RDATA & 8'hf4) == 8'hf4)
		else $error("used byte1 not forced");
	a_error_undef_zero: assert property (REG_RD && REG_ADDR == 8'h24
		|=> REG_RDATA[5:4] == 2'b00)
		else $error("error report bits 5:4 set");
	a_emphasis_follows: assert property (HEADER_LOAD
		|=> EMPHASIS_FIELD == $past(USED_HEADER[1:0]))
		else $error("emphasis not latched");
	cover property (REG_RD && REG_ADDR == 8'h1c ##1 REG_RDATA != 8'h00);
	cover property ($fell(INTERRUPT_OUT_PIN));
	cover property (HEADER_LOAD ##[1:40] REG_RD && REG_ADDR == 8'h22);
endmodule // status_irq_chk
bind mpeg_decoder_status_irq_regs status_irq_chk i_chk (.*);

// ### sim/mpeg_decoder_status_irq_regs_bench.sv
// self-checking bench for the status and interrupt register bank
// host model drives the register port; core inputs change at the falling edge
`timescale 1ns/1ps
module mpeg_decoder_status_irq_regs_bench;
	reg CLK = 1'b0;
	reg SRST = 1'b1;
	reg DATA_READY_FLAG = 1'b0;
	reg IN_SYNC_FLAG = 1'b0;
	reg CRC_FAIL = 1'b0;
	reg STOP_PIN = 1'b0;
	reg HEADER_LOAD = 1'b0;
	reg ERROR_LOAD = 1'b0;
	reg [23:0] DECODED_HEADER = 24'h5a6b97;
	reg [23:0] USED_HEADER = 24'h0a6b96;
	reg [7:0] ERROR_REPORT = 8'hfa;
	wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
	wire REG_RD, REG_WR, REG_RVALID, INTERRUPT_OUT_PIN;
	wire [1:0] EMPHASIS_FIELD;
	integer n_mismatch = 0;
	integer samples_checked = 0;
	integer k;
	reg [7:0] d;
	reg [15:0] rows [0:7];
	always #2 CLK = ~CLK;
	mpeg_decoder_status_irq_regs i_dut (.*);
	status_host i_host (.*);
	task chk(input [7:0] got, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				$display("[FAIL] %0t got %h want %h", $time, got, exp);
				n_mismatch = n_mismatch + 1;
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
			if (n_mismatch == 0 && samples_checked > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (3) @(negedge CLK);
		SRST = 1'b0;
		i_host.rd(8'h1c, d);
		chk(d, 8'h00);
		chk({7'h0, INTERRUPT_OUT_PIN}, 8'h00);
		$display("reset test done");
		@(negedge CLK);
		HEADER_LOAD = 1'b1;
		ERROR_LOAD = 1'b1;
		@(negedge CLK);
		HEADER_LOAD = 1'b0;
		ERROR_LOAD = 1'b0;
		chk({6'h0, EMPHASIS_FIELD}, {6'h0, USED_HEADER[1:0]});
		// block reads, continuation ends in zeros, 01 unmapped
		rows[0] = {8'h21, DECODED_HEADER[23:16]};
		rows[1] = {8'h00, DECODED_HEADER[15:8] & 8'hfc};
		rows[2] = {8'h00, DECODED_HEADER[7:0]};
		rows[3] = {8'h00, 8'h00};
		rows[4] = {8'h22, USED_HEADER[23:16] | 8'hf4};
		rows[5] = {8'h24, ERROR_REPORT & 8'hcf};
		rows[6] = {8'h00, 8'h00};
		rows[7] = {8'h01, 8'h00};
		for (k = 0; k < 8; k = k + 1) begin
			i_host.rd(rows[k][15:8], d);
			chk(d, rows[k][7:0]);
		end
		$display("table test done");
		i_host.wr(8'h1d, 5'h1f);
		@(negedge CLK);
		CRC_FAIL = 1'b1;
		IN_SYNC_FLAG = 1'b1;
		DATA_READY_FLAG = 1'b1;
		STOP_PIN = 1'b1;
		@(negedge CLK);
		CRC_FAIL = 1'b0;
		// stop pin passes a synchroniser first
		repeat (6) @(negedge CLK);
		chk({7'h0, INTERRUPT_OUT_PIN}, 8'h01);
		i_host.rd(8'h1c, d);
		chk(d, 8'h1e);
		chk({7'h0, INTERRUPT_OUT_PIN}, 8'h00);
		i_host.wr(8'h1d, 5'h1e);
		@(negedge CLK);
		IN_SYNC_FLAG = 1'b0;
		repeat (2) @(negedge CLK);
		chk({7'h0, INTERRUPT_OUT_PIN}, 8'h00);
		i_host.rd(8'h1c, d);
		chk(d, 8'h01);
		$display("event test done");
		finish_test;
	end
	// run needs about 42 cycles; this allows over twenty times that
	initial begin
		#4000;
		n_mismatch = n_mismatch + 1;
		finish_test;
	end
endmodule // mpeg_decoder_status_irq_regs_bench
